// file: srlm_asserts.sv
/* Port checks of srlm_top, bound into every instance.
   Assumes every checked output belongs to the clk domain. */
`timescale 1ns/1ps
`default_nettype none
module srlm_asserts #(
	parameter int W = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sleep_n,
	input wire logic line_driver_enable,
	input wire logic serial_out_p,
	input wire logic serial_out_n,
	input wire logic serial_out_oe,
	input wire logic tx_in_ready,
	input wire logic sleep_input_n,
	input wire logic rx_output_enable,
	input wire logic [W-1:0] parallel_out_word,
	input wire logic lock_n,
	input wire logic recovered_clock,
	input wire logic rx_outputs_oe
);
	logic seen_lock_ff; // A lock was reported since reset
	// Sticky, so a later sleep does not hide an earlier lock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seen_lock_ff <= 1'b0;
		end else if (!lock_n) begin
			seen_lock_ff <= 1'b1;
		end
	end
	// Pins pass a synchronizer first, so levels get six cycles to act
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_pair_opposite: assert property (serial_out_oe |-> serial_out_p != serial_out_n)
		else $error("serial pair not complementary");
	a_sleep_unlock: assert property (!sleep_input_n [*6] |-> lock_n)
		else $error("lock_n low while receiver asleep");
	a_oe_after_lock: assert property ($rose(rx_outputs_oe) |-> ##[0:4] seen_lock_ff)
		else $error("receiver outputs driven before lock");
	a_oe_cause: assert property ($rose(rx_outputs_oe) |-> $past(rx_output_enable))
		else $error("receiver outputs driven without enable");
	a_rx_float: assert property (!rx_output_enable [*6] |-> !rx_outputs_oe)
		else $error("receiver outputs driven while disabled");
	a_tx_float: assert property (!line_driver_enable [*6] |-> !serial_out_oe)
		else $error("serial output driven while disabled");
	a_tx_asleep: assert property (!sleep_n [*6] |-> !tx_in_ready && !serial_out_oe)
		else $error("serializer active while asleep");
	a_word_strobe: assert property ($changed(parallel_out_word) |-> recovered_clock)
		else $error("word changed without recovered clock");
	a_hunt_hold: assert property (lock_n [*8] |-> $stable(parallel_out_word))
		else $error("word changed while hunting");
	c_locked: cover property ($fell(lock_n));
	c_lost: cover property ($rose(lock_n));
	c_word: cover property (recovered_clock && !lock_n);
	c_full: cover property ($fell(tx_in_ready) && sleep_n);
endmodule
bind srlm_top srlm_asserts #(.W(W)) srlm_asserts_inst (
	.clk(clk), .rst_n(rst_n), .sleep_n(sleep_n), .line_driver_enable(line_driver_enable),
	.serial_out_p(serial_out_p), .serial_out_n(serial_out_n),
	.serial_out_oe(serial_out_oe), .tx_in_ready(tx_in_ready), .sleep_input_n(sleep_input_n),
	.rx_output_enable(rx_output_enable), .parallel_out_word(parallel_out_word),
	.lock_n(lock_n), .recovered_clock(recovered_clock), .rx_outputs_oe(rx_outputs_oe)
);
`default_nettype wire

// file: srlm_fifo2.sv
/*
 * Small flip-flop FIFO with valid/ready on both sides.
 * Assumes a single clock; full and empty flags are registered.
 */
`timescale 1ns/1ps
`default_nettype none
module srlm_fifo2 #(
	parameter int W = 10,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	logic [W-1:0] mem_ff [DEPTH];	// Storage entries
	logic [AW-1:0] wr_ff;	// Write index
	logic [AW-1:0] rd_ff;	// Read index
	logic [CW-1:0] cnt_ff;	// Occupancy
	logic [CW-1:0] nxt_cnt;
	logic full_ff;
	logic empty_ff;
	logic push;
	logic pop;

	// Advance an index with wrap
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] i);
		return (i == AW'(DEPTH - 1)) ? '0 : i + 1'b1;
	endfunction

	assign push = in_valid && !full_ff;
	assign pop = out_ready && !empty_ff;
	assign in_ready = !full_ff;
	assign out_valid = !empty_ff;
	assign out_data = mem_ff[rd_ff];

	// Occupancy after this cycle
	always_comb begin
		nxt_cnt = cnt_ff;
		if (push && !pop) begin
			nxt_cnt = cnt_ff + 1'b1;
		end else if (pop && !push) begin
			nxt_cnt = cnt_ff - 1'b1;
		end
	end

	// Pointers and flags; flags registered so ready is glitch free
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
			full_ff <= 1'b0;
			empty_ff <= 1'b1;
		end else begin
			if (push) begin
				wr_ff <= bump(wr_ff);
			end
			if (pop) begin
				rd_ff <= bump(rd_ff);
			end
			cnt_ff <= nxt_cnt;
			full_ff <= (nxt_cnt == CW'(DEPTH));
			empty_ff <= (nxt_cnt == '0);
		end
	end

	// Data entries carry no reset
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end
endmodule
`default_nettype wire

// file: srlm_link_model.sv
/* Far end of the link: a remote serializer on the bit clock and a
   receiver that deframes the design's serial output, one bit per clk.
   Assumes the bit clock runs free, as a reference clock does. */
`timescale 1ns/1ps
`default_nettype none
module srlm_link_model (
	input wire logic clk,
	input wire logic link_bit_clk,
	input wire logic send_sync,
	input wire logic send_bad,
	input wire logic [9:0] send_word,
	output logic serial_in,
	output logic frame_sent,
	input wire logic serial_out_p,
	input wire logic serial_out_oe,
	output logic [9:0] got_word,
	output logic got_valid,
	output logic got_ok
);
	import srlm_pkg::*;
	logic [3:0] bit_ff = 4'h0; // Bit slot in the outgoing frame
	logic [11:0] frm_ff = 12'h0; // Frame being sent
	logic [11:0] win_ff = 12'h0; // Last received bits
	logic [3:0] cnt_ff = 4'h0; // Bit slot in the received frame
	logic hold_ff = 1'b0; // Receiver aligned
	logic [11:0] nxt_win;
	// A released line shows the inverse of the last bit, never a stale copy
	assign nxt_win = {win_ff[10:0], serial_out_oe ? serial_out_p : !serial_out_p};
	// Pattern or framed word, bad clock bits on demand
	always_ff @(posedge link_bit_clk) begin
		bit_ff <= (bit_ff == FRAME_LAST) ? 4'h0 : bit_ff + 4'h1;
		frame_sent <= (bit_ff == FRAME_LAST);
		serial_in <= frm_ff[FRAME_LAST - bit_ff];
		if (bit_ff == FRAME_LAST) begin
			frm_ff <= send_sync ? {START_BIT, ALIGN_PATTERN, STOP_BIT}
				: {START_BIT ^ send_bad, send_word, STOP_BIT ^ send_bad};
		end
	end
	// Floating line drops alignment; the pattern restores it
	always_ff @(posedge clk) begin
		win_ff <= nxt_win;
		got_valid <= 1'b0;
		cnt_ff <= (cnt_ff == FRAME_LAST) ? 4'h0 : cnt_ff + 4'h1;
		if (!serial_out_oe) begin
			hold_ff <= 1'b0;
		end else if (!hold_ff && nxt_win == {START_BIT, ALIGN_PATTERN, STOP_BIT}) begin
			hold_ff <= 1'b1;
			cnt_ff <= 4'h0;
		end else if (hold_ff && cnt_ff == FRAME_LAST) begin
			got_valid <= 1'b1;
			got_word <= nxt_win[10:1];
			got_ok <= nxt_win[11] & ~nxt_win[0];
		end
	end
endmodule
`default_nettype wire

// file: srlm_pkg.sv
/*
 * Shared constants and state types of the serial link lock manager.
 * Assumes one design clock (clk) and one link bit clock; no bus, plain pins.
 */
// Operation
// - Serializer frames each 10-bit word, adds clock bits
// - Lock indicator high whenever receiver not locked
// - Patterns sent while either request is high
// - Loss declared after four consecutive bad frames
// - Output words valid while lock indicator low
// - Receiver outputs high impedance until first lock
// - Sleep toggle resets serializer PLL
// - Request gives at least 1024 pattern words
// - Edge select picks rising or falling capture
// - Output enable low floats receiver outputs
// - Driver enable low floats serial output
package srlm_pkg;
	localparam int WORD_W = 10;
	localparam int FRAME_BITS = 12;
	localparam int FRAME_CNT_W = 4;
	localparam logic [FRAME_CNT_W-1:0] FRAME_LAST = 4'hb;
	localparam logic START_BIT = 1'b1;
	localparam logic STOP_BIT = 1'b0;
	localparam logic [WORD_W-1:0] ALIGN_PATTERN = 10'h3e0;
	localparam int SYNC_CNT_W = 11;
	localparam logic [SYNC_CNT_W-1:0] SYNC_MIN_WORDS = 11'h400;
	localparam int BAD_CNT_W = 3;
	localparam logic [BAD_CNT_W-1:0] LOSS_BAD_WORDS = 3'h4;
	localparam int PLL_CNT_W = 12;
	localparam logic [PLL_CNT_W-1:0] PLL_LOCK_CYCLES = 12'h800;
	localparam int FIFO_DEPTH = 2;

	// Serializer states
	typedef enum logic [2:0] {
		SRLM_TX_SLEEP = 3'b001,
		SRLM_TX_PLL = 3'b010,
		SRLM_TX_RUN = 3'b100
	} srlm_tx_state_t;

	// Receiver alignment states
	typedef enum logic [1:0] {
		SRLM_RX_HUNT = 2'b01,
		SRLM_RX_LOCK = 2'b10
	} srlm_rx_state_t;
endpackage

// file: srlm_top.sv
/*
 * Serializer and deserializer lock manager: framing, pattern requests,
 * lock detection, sleep sequencing and output enables.
 * Assumes clk runs the serializer and parallel outputs; link_bit_clk is the
 * bit clock delivered with the incoming serial stream, one bit per rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module srlm_top #(
	parameter int W = srlm_pkg::WORD_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic link_bit_clk,
	input wire logic transmit_word_clock,
	input wire logic tx_capture_edge_select,
	input wire logic [W-1:0] parallel_in_word,
	output logic tx_in_ready,
	input wire logic pattern_request_a,
	input wire logic pattern_request_b,
	input wire logic sleep_n,
	input wire logic line_driver_enable,
	output logic serial_out_p,
	output logic serial_out_n,
	output logic serial_out_oe,
	input wire logic serial_in,
	input wire logic sleep_input_n,
	input wire logic rx_output_enable,
	output logic [W-1:0] parallel_out_word,
	output logic lock_n,
	output logic recovered_clock,
	output logic rx_outputs_oe
);
	import srlm_pkg::*;

	// Pin synchronizers in clk domain (stage 1 read only by stage 2)
	logic [W+6:0] pin_s1_ff;
	logic [W+6:0] pin_s2_ff;
	logic twc_prev_ff;	// Word clock level one cycle back
	logic [W-1:0] din_s;
	logic twc_s;
	logic edge_sel_s;
	logic req_s;
	logic sleep_s;
	logic drv_en_s;
	logic ren_s;
	logic rx_sleep_s;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
			twc_prev_ff <= 1'b0;
		end else begin
			pin_s1_ff <= {sleep_input_n, rx_output_enable, line_driver_enable, sleep_n,
				pattern_request_a | pattern_request_b, tx_capture_edge_select,
				transmit_word_clock, parallel_in_word};
			pin_s2_ff <= pin_s1_ff;
			twc_prev_ff <= pin_s2_ff[W];
		end
	end
	assign din_s = pin_s2_ff[W-1:0];
	assign twc_s = pin_s2_ff[W];
	assign edge_sel_s = pin_s2_ff[W+1];
	assign req_s = pin_s2_ff[W+2];
	assign sleep_s = pin_s2_ff[W+3];
	assign drv_en_s = pin_s2_ff[W+4];
	assign ren_s = pin_s2_ff[W+5];
	assign rx_sleep_s = pin_s2_ff[W+6];

	// Serializer sequencing
	srlm_tx_state_t tx_state_ff;
	logic [PLL_CNT_W-1:0] pll_cnt_ff;	// PLL settle countdown
	logic [SYNC_CNT_W-1:0] sync_cnt_ff;	// Pattern words still owed
	logic [FRAME_CNT_W-1:0] tx_bit_ff;	// Bit position in frame
	logic [FRAME_BITS-1:0] tx_sh_ff;	// Outgoing frame shifter
	logic cap_edge;
	logic fifo_valid;
	logic fifo_in_ready;	// Buffer has a free entry
	logic [W-1:0] fifo_data;
	logic frame_start;
	logic send_pattern;
	logic pop_word;

	// rising edge when select high, falling when low
	assign cap_edge = (tx_state_ff == SRLM_TX_RUN) &&
		(edge_sel_s ? (twc_s && !twc_prev_ff) : (!twc_s && twc_prev_ff));
	assign frame_start = (tx_state_ff == SRLM_TX_RUN) && (tx_bit_ff == '0);
	// patterns win over data while requested
	assign send_pattern = req_s || (sync_cnt_ff != '0) || !fifo_valid;
	assign pop_word = frame_start && !send_pattern;

	// Two-entry buffer; a full buffer drops the capture and shows tx_in_ready low
	srlm_fifo2 #(.W(W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(cap_edge),
		.in_ready(fifo_in_ready),
		.in_data(din_s),
		.out_valid(fifo_valid),
		.out_ready(pop_word),
		.out_data(fifo_data)
	);

	// Sleep and PLL settle state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_ff <= SRLM_TX_SLEEP;
			pll_cnt_ff <= '0;
		end else begin
			case (tx_state_ff)
				SRLM_TX_SLEEP: begin
					// leaving sleep restarts the PLL from scratch
					if (sleep_s) begin
						tx_state_ff <= SRLM_TX_PLL;
						pll_cnt_ff <= PLL_LOCK_CYCLES;
					end
				end
				SRLM_TX_PLL: begin
					if (!sleep_s) begin
						tx_state_ff <= SRLM_TX_SLEEP;
					end else if (pll_cnt_ff == 12'h001) begin
						tx_state_ff <= SRLM_TX_RUN;
					end
					pll_cnt_ff <= pll_cnt_ff - 1'b1;
				end
				SRLM_TX_RUN: begin
					if (!sleep_s) begin
						tx_state_ff <= SRLM_TX_SLEEP;
					end
				end
				default: begin
					tx_state_ff <= SRLM_TX_SLEEP;
				end
			endcase
		end
	end

	// Pattern minimum counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_cnt_ff <= '0;
		end else if (tx_state_ff != SRLM_TX_RUN) begin
			sync_cnt_ff <= '0;
		end else if (req_s) begin
			// a request owes at least the minimum burst
			sync_cnt_ff <= SYNC_MIN_WORDS;
		end else if (frame_start && sync_cnt_ff != '0) begin
			sync_cnt_ff <= sync_cnt_ff - 1'b1;
		end
	end

	// Frame shifter, one bit per clk
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_bit_ff <= '0;
			tx_sh_ff <= '0;
		end else if (tx_state_ff != SRLM_TX_RUN) begin
			tx_bit_ff <= '0;
		end else if (frame_start) begin
			// two clock bits wrap each word
			// start, ten data, stop of opposite level
			tx_sh_ff <= {START_BIT, send_pattern ? ALIGN_PATTERN : fifo_data, STOP_BIT};
			tx_bit_ff <= tx_bit_ff + 1'b1;
		end else begin
			tx_sh_ff <= {tx_sh_ff[FRAME_BITS-2:0], 1'b0};
			tx_bit_ff <= (tx_bit_ff == FRAME_LAST) ? '0 : tx_bit_ff + 1'b1;
		end
	end

	// Serial pins and buffer ready, all registered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_out_p <= 1'b0;
			serial_out_n <= 1'b1;
			serial_out_oe <= 1'b0;
			tx_in_ready <= 1'b0;
		end else begin
			serial_out_p <= tx_sh_ff[FRAME_BITS-1];
			serial_out_n <= !tx_sh_ff[FRAME_BITS-1];
			// driver enable low floats the line
			serial_out_oe <= drv_en_s && (tx_state_ff == SRLM_TX_RUN);
			tx_in_ready <= (tx_state_ff == SRLM_TX_RUN) && fifo_in_ready;
		end
	end

	// Link domain: receiver alignment and lock detection
	logic [1:0] rx_s1_ff;	// Serial bit and sleep, first stage
	logic [1:0] rx_s2_ff;
	srlm_rx_state_t rx_state_ff;
	logic [FRAME_BITS-1:0] rx_sh_ff;	// Last twelve bits seen
	logic [FRAME_BITS-1:0] nxt_rx_sh;
	logic [FRAME_CNT_W-1:0] rx_bit_ff;
	logic [BAD_CNT_W-1:0] bad_cnt_ff;	// Consecutive bad frames
	logic [W-1:0] rx_hold_ff;	// Word held for the crossing
	logic rx_tgl_ff;	// Flips once per published word
	logic ref_div_ff;	// Reference rate tick for acquiring
	logic frame_ok;

	assign nxt_rx_sh = {rx_sh_ff[FRAME_BITS-2:0], rx_s2_ff[0]};
	assign frame_ok = (nxt_rx_sh[FRAME_BITS-1] == START_BIT) && (nxt_rx_sh[0] == STOP_BIT);

	always_ff @(posedge link_bit_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_s1_ff <= '0;
			rx_s2_ff <= '0;
			ref_div_ff <= 1'b0;
		end else begin
			rx_s1_ff <= {sleep_input_n, serial_in};
			rx_s2_ff <= rx_s1_ff;
			ref_div_ff <= !ref_div_ff;
		end
	end

	// Hunt for the alignment frame, then track frame boundaries
	always_ff @(posedge link_bit_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_state_ff <= SRLM_RX_HUNT;
			rx_sh_ff <= '0;
			rx_bit_ff <= '0;
			bad_cnt_ff <= '0;
			rx_hold_ff <= '0;
			rx_tgl_ff <= 1'b0;
		end else begin
			rx_sh_ff <= nxt_rx_sh;
			case (rx_state_ff)
				SRLM_RX_HUNT: begin
					bad_cnt_ff <= '0;
					rx_bit_ff <= '0;
					if (rx_s2_ff[1] && frame_ok &&
						nxt_rx_sh[FRAME_BITS-2:1] == ALIGN_PATTERN) begin
						rx_state_ff <= SRLM_RX_LOCK;
					end
				end
				SRLM_RX_LOCK: begin
					rx_bit_ff <= (rx_bit_ff == FRAME_LAST) ? '0 : rx_bit_ff + 1'b1;
					if (!rx_s2_ff[1]) begin
						rx_state_ff <= SRLM_RX_HUNT;
					end else if (rx_bit_ff == FRAME_LAST) begin
						if (frame_ok) begin
							bad_cnt_ff <= '0;
							// only intact data frames are published
							if (nxt_rx_sh[FRAME_BITS-2:1] != ALIGN_PATTERN) begin
								rx_hold_ff <= nxt_rx_sh[FRAME_BITS-2:1];
								rx_tgl_ff <= !rx_tgl_ff;
							end
						end else if (bad_cnt_ff == LOSS_BAD_WORDS - 1'b1) begin
							// fourth bad frame in a row drops lock
							rx_state_ff <= SRLM_RX_HUNT;
						end else begin
							bad_cnt_ff <= bad_cnt_ff + 1'b1;
						end
					end
				end
				default: begin
					rx_state_ff <= SRLM_RX_HUNT;
				end
			endcase
		end
	end

	// Crossing into clk: lock level, word toggle, reference tick
	logic [2:0] x_s1_ff;
	logic [2:0] x_s2_ff;
	logic tgl_prev_ff;
	logic seen_lock_ff;	// Set at first lock, cleared by sleep
	logic locked_s;
	logic new_word;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			x_s1_ff <= '0;
			x_s2_ff <= '0;
			tgl_prev_ff <= 1'b0;
		end else begin
			x_s1_ff <= {ref_div_ff, rx_tgl_ff, rx_state_ff == SRLM_RX_LOCK};
			x_s2_ff <= x_s1_ff;
			tgl_prev_ff <= x_s2_ff[1];
		end
	end
	assign locked_s = x_s2_ff[0];
	// Hold word stays still twelve link bits, far beyond the sync delay
	// sleep reaches this side before the link drops lock, so gate on it too
	assign new_word = locked_s && rx_sleep_s && (x_s2_ff[1] != tgl_prev_ff);

	// Receiver parallel outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			parallel_out_word <= '0;
			lock_n <= 1'b1;
			recovered_clock <= 1'b0;
			seen_lock_ff <= 1'b0;
			rx_outputs_oe <= 1'b0;
		end else begin
			lock_n <= !locked_s || !rx_sleep_s;
			// words move only while locked; the clock shows the reference tick when not locked
			if (new_word) begin
				parallel_out_word <= rx_hold_ff;
			end
			recovered_clock <= locked_s ? new_word : x_s2_ff[2];
			// stay floating until the first lock
			if (!rx_sleep_s) begin
				seen_lock_ff <= 1'b0;
			end else if (locked_s) begin
				seen_lock_ff <= 1'b1;
			end
			// output enable low floats all receiver outputs
			rx_outputs_oe <= ren_s && seen_lock_ff && rx_sleep_s;
		end
	end
endmodule
`default_nettype wire

// file: srlm_top_tb_top.sv
/* Self-checking bench of srlm_top with the far-end model on the link.
   Assumes package, design, checker and model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module srlm_top_tb_top;
	import srlm_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b1; // Driven low just after time zero so both domains see the edge
	logic link_bit_clk = 1'b0;
	logic twc, sel, req_a, req_b, slp, drv_en, slp_rx, ren, serial_in;
	logic rdy, sp, sn, soe, lk_n, rclk, roe, fsent, got_valid, got_ok;
	logic m_sync = 1'b1;
	logic m_bad = 1'b0;
	logic skip = 1'b0; // Ignore words around a loss of lock
	logic [9:0] din, pout, got_word;
	logic [9:0] m_word = 10'h0;
	logic [31:0] lfsr = 32'h38f5;
	logic [9:0] txq[$], rxq[$], hist[$];
	int errors = 0;
	int comparisons = 0;
	int pats = 0;
	int cyc = 0;
	always #2.5 clk = ~clk;
	// Reference clock runs free, offset so its edges never meet clk
	initial begin
		#2.3;
		forever #7.5 link_bit_clk = ~link_bit_clk;
	end
	srlm_top srlm_top_inst (
		.clk(clk), .rst_n(rst_n), .link_bit_clk(link_bit_clk), .transmit_word_clock(twc),
		.tx_capture_edge_select(sel), .parallel_in_word(din), .tx_in_ready(rdy),
		.pattern_request_a(req_a), .pattern_request_b(req_b), .sleep_n(slp),
		.line_driver_enable(drv_en), .serial_out_p(sp), .serial_out_n(sn), .serial_out_oe(soe),
		.serial_in(serial_in), .sleep_input_n(slp_rx), .rx_output_enable(ren),
		.parallel_out_word(pout), .lock_n(lk_n), .recovered_clock(rclk), .rx_outputs_oe(roe)
	);
	// lock indicator also asks the far end for patterns
	srlm_link_model srlm_link_model_inst (
		.clk(clk), .link_bit_clk(link_bit_clk), .send_sync(m_sync | lk_n), .send_bad(m_bad),
		.send_word(m_word), .serial_in(serial_in), .frame_sent(fsent), .serial_out_p(sp),
		.serial_out_oe(soe), .got_word(got_word), .got_valid(got_valid), .got_ok(got_ok)
	);
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic end_sim;
		if (errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk1(input string what, input logic exp, input logic got);
		check(what, {9'h0, exp}, {9'h0, got});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic frames(input int n);
		repeat (n) @(posedge fsent);
		tick(1);
	endtask
	// Pattern words are never published, so they are kept out
	task automatic rnd(output logic [9:0] w);
		lfsr = lfsr_next(lfsr);
		w = (lfsr[9:0] == ALIGN_PATTERN) ? ~lfsr[9:0] : lfsr[9:0];
	endtask
	// Edge select moves first so the idle level change never captures
	task automatic put;
		logic [9:0] w;
		rnd(w);
		sel = lfsr[12];
		tick(4);
		twc = !sel;
		din = w;
		tick(4);
		if (rdy === 1'b1) txq.push_back(w);
		twc = sel;
		tick(6);
	endtask
	task automatic until_rdy;
		for (int k = 0; k < 3000 && rdy !== 1'b1; k++) tick(1);
	endtask
	task automatic drain;
		for (int k = 0; k < 16000 && txq.size() != 0; k++) tick(1);
		chk1("tx_drained", 1'b1, txq.size() == 0);
	endtask
	task automatic wait_lock;
		for (int k = 0; k < 3000 && lk_n !== 1'b0; k++) tick(1);
		chk1("lock_n", 1'b0, lk_n);
	endtask
	// Remote words, fresh or the latest ones again
	task automatic rx_words(input int n, input logic rep);
		logic [9:0] w;
		m_sync = 1'b0;
		for (int i = 0; i < n; i++) begin
			if (rep) w = hist[hist.size() - n + i];
			else rnd(w);
			if (!rep) hist.push_back(w);
			m_word = w;
			rxq.push_back(w);
			frames(1);
		end
		m_sync = 1'b1;
		frames(2);
	endtask
	// Oldest note against each result, in both directions
	always @(posedge clk) begin
		if (got_valid === 1'b1) begin
			chk1("frame_bits", 1'b1, got_ok);
			if (got_word === ALIGN_PATTERN) pats++;
			else check("serial_word", txq.size() ? txq.pop_front() : ~got_word, got_word);
		end
		if (lk_n === 1'b0 && rclk === 1'b1 && !skip)
			check("parallel_out_word", rxq.size() ? rxq.pop_front() : ~pout, pout);
		cyc++;
		if (cyc == 80000) begin
			errors++;
			end_sim();
		end
	end
	initial begin
		twc = 1'b0; sel = 1'b0; din = 10'h0; req_a = 1'b0; req_b = 1'b0;
		slp = 1'b0; drv_en = 1'b1; slp_rx = 1'b0; ren = 1'b1;
		// Sleep pins low through reset and ramp
		tick(0);
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
		tick(4);
		slp_rx = 1'b1;
		chk1("rx_outputs_oe", 1'b0, roe);
		wait_lock();
		rx_words(6, 1'b0);
		skip = 1'b1;
		m_sync = 1'b0;
		m_bad = 1'b1;
		frames(3);
		m_bad = 1'b0;
		frames(2);
		chk1("lock_n", 1'b0, lk_n);
		m_bad = 1'b1;
		frames(4);
		m_bad = 1'b0;
		m_sync = 1'b1;
		frames(1);
		tick(20);
		chk1("lock_n", 1'b1, lk_n);
		wait_lock();
		skip = 1'b0;
		rx_words(5, 1'b1);
		ren = 1'b0;
		tick(8);
		chk1("rx_outputs_oe", 1'b0, roe);
		ren = 1'b1;
		tick(8);
		chk1("rx_outputs_oe", 1'b1, roe);
		slp_rx = 1'b0;
		tick(8);
		chk1("lock_n", 1'b1, lk_n);
		slp_rx = 1'b1;
		wait_lock();
		slp = 1'b1;
		tick(10);
		slp = 1'b0;
		put();
		chk1("tx_in_ready", 1'b0, rdy);
		slp = 1'b1;
		until_rdy();
		chk1("tx_in_ready", 1'b1, rdy);
		tick(300);
		repeat (4) begin
			until_rdy();
			put();
		end
		drain();
		drv_en = 1'b0;
		tick(8);
		chk1("serial_out_oe", 1'b0, soe);
		drv_en = 1'b1;
		tick(300);
		for (int i = 0; i < 2; i++) begin
			{req_b, req_a} = 2'b01 << i;
			tick(4);
			put();
			put();
			tick(2);
			chk1("tx_in_ready", 1'b0, rdy);
			put();
			tick(100);
			chk1("words_held", 1'b1, txq.size() == 2);
			{req_b, req_a} = 2'b00;
			pats = 0;
			drain();
			chk1("pattern_frames", 1'b1, pats >= int'(SYNC_MIN_WORDS));
		end
		end_sim();
	end
endmodule
`default_nettype wire
